// ==== logic/xfer_test_core.sv ====
// decode and execute for transfer, test, wait and software trap opcodes
// assumes program memory answers a read in the same cycle (rdata_i valid
// for the address presented); wake_i is synchronised here
//
// Functional notes
// - opcode 97 copies accumulator to index in 2 cycles, flags unchanged
// - opcode 9F copies index to accumulator in 2 cycles, flags unchanged
// - test computes operand minus 00, sets N and Z, keeps C H I
// - 4D tests accumulator, 5D tests index, each in 3 cycles
// - 6D tests memory at index plus 8-bit offset, 5 cycles
// - 7D tests memory at index in 4; 3D direct in 4 cycles
// - 16-bit indexed address is index plus offset fetched high then low
// - 8F clears I, halts CPU clock until interrupt, counted 2 cycles
module xfer_test_core
	import xfer_test_pkg::*;
(
	input  wire logic        mclk_i,
	input  wire logic        srst_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic        wake_i,
	output mem_req_t         mem_o,
	output cpu_regs_t        regs_o,
	output logic             cpu_clk_en_o,
	output logic             instr_done_o
);
	state_t      state_ff;
	cpu_regs_t   regs_ff;
	mem_req_t    mem_ff;
	logic [7:0]  op_ff;
	logic [3:0]  cyc_ff;
	logic [3:0]  len_ff;
	logic [7:0]  byte_ff;
	logic [2:0]  push_ff;
	logic        wake_s1_ff;
	logic        wake_s2_ff;
	logic        clk_en_ff;
	logic        done_ff;
	logic [4:0]  tested_flags;
	logic [7:0]  test_src;
	logic [15:0] ofs16_addr;

	function automatic logic [3:0] op_len(input logic [7:0] op);
		case (op)
			OP_COPY_ACC_TO_INDEX: op_len = CYC_COPY;
			OP_COPY_INDEX_TO_ACC: op_len = CYC_COPY;
			OP_TEST_ACCUMULATOR:  op_len = CYC_TEST_REG;
			OP_TEST_INDEX_REG:    op_len = CYC_TEST_REG;
			OP_TEST_DIRECT:       op_len = CYC_TEST_DIR;
			OP_TEST_NO_OFFSET:    op_len = CYC_TEST_NOOFS;
			OP_TEST_OFFSET8:      op_len = CYC_TEST_OFS8;
			OP_WAIT_IRQ:          op_len = CYC_WAIT;
			OP_SOFTWARE_TRAP:     op_len = CYC_TRAP;
			default:              op_len = CYC_UNKNOWN;
		endcase
	endfunction

	// operand reaching the flag unit: register for inherent, memory otherwise
	always_comb begin
		case (op_ff)
			OP_TEST_ACCUMULATOR: test_src = regs_ff.acc;
			OP_TEST_INDEX_REG:   test_src = regs_ff.idx;
			default:             test_src = rdata_i;
		endcase
	end

	test_flags u_flags (
		.operand_i (test_src),
		.flags_i   (regs_ff.condition_code_reg),
		.flags_o   (tested_flags)
	);

	assign ofs16_addr = indexed_offset16(regs_ff.idx, byte_ff, rdata_i);

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			wake_s1_ff <= 1'b0;
			wake_s2_ff <= 1'b0;
		end else begin
			wake_s1_ff <= wake_i;
			wake_s2_ff <= wake_s1_ff;
		end
	end

	// sequencer: cyc_ff counts cycles of the current instruction from 1
	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			state_ff  <= ST_FETCH;
			regs_ff   <= '{acc: 8'h00, idx: 8'h00, condition_code_reg: RST_FLAGS,
				sp: RST_SP, pc: RST_PC};
			mem_ff    <= '{we: 1'b0, addr: RST_PC, data: 8'h00};
			op_ff     <= 8'h00;
			cyc_ff    <= 4'h0;
			len_ff    <= 4'h0;
			byte_ff   <= 8'h00;
			push_ff   <= 3'h0;
			clk_en_ff <= 1'b1;
			done_ff   <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			case (state_ff)
				ST_FETCH: begin
					op_ff        <= rdata_i;
					len_ff       <= op_len(rdata_i);
					cyc_ff       <= 4'h1;
					regs_ff.pc   <= regs_ff.pc + 16'h0001;
					mem_ff.addr  <= regs_ff.pc + 16'h0001;
					state_ff     <= ST_EXEC;
				end
				ST_EXEC: begin
					cyc_ff <= cyc_ff + 4'h1;
					case (op_ff)
						OP_COPY_ACC_TO_INDEX: regs_ff.idx <= regs_ff.acc;
						OP_COPY_INDEX_TO_ACC: regs_ff.acc <= regs_ff.idx;
						OP_TEST_ACCUMULATOR, OP_TEST_INDEX_REG: begin
							if (cyc_ff == CYC_TEST_REG - 4'h1)
								regs_ff.condition_code_reg <= tested_flags;
						end
						OP_TEST_DIRECT: begin
							if (cyc_ff == 4'h1) begin
								regs_ff.pc  <= regs_ff.pc + 16'h0001;
								mem_ff.addr <= {8'h00, rdata_i};
							end else if (cyc_ff == CYC_TEST_DIR - 4'h1) begin
								regs_ff.condition_code_reg <= tested_flags;
							end
						end
						OP_TEST_OFFSET8: begin
							if (cyc_ff == 4'h1) begin
								regs_ff.pc  <= regs_ff.pc + 16'h0001;
								mem_ff.addr <= {8'h00, regs_ff.idx} + {8'h00, rdata_i};
							end else if (cyc_ff == CYC_TEST_OFS8 - 4'h1) begin
								regs_ff.condition_code_reg <= tested_flags;
							end
						end
						OP_TEST_NO_OFFSET: begin
							if (cyc_ff == 4'h1)
								mem_ff.addr <= {8'h00, regs_ff.idx};
							else if (cyc_ff == CYC_TEST_NOOFS - 4'h1)
								regs_ff.condition_code_reg <= tested_flags;
						end
						OP_WAIT_IRQ: regs_ff.condition_code_reg[FLAG_I] <= 1'b0;
						OP_SOFTWARE_TRAP: begin
							if (cyc_ff == 4'h2) begin
								state_ff   <= ST_PUSH;
								push_ff    <= 3'h0;
								mem_ff     <= '{we: 1'b1, addr: {8'h00, regs_ff.sp},
									data: regs_ff.pc[7:0]};
							end
						end
						default: ;
					endcase
					if (op_ff != OP_SOFTWARE_TRAP && cyc_ff == len_ff - 4'h1) begin
						done_ff <= 1'b1;
						if (op_ff == OP_WAIT_IRQ) begin
							clk_en_ff <= 1'b0;
							state_ff  <= ST_WAITING;
						end else begin
							state_ff    <= ST_FETCH;
							mem_ff.addr <= regs_ff.pc;
						end
					end
					if (op_ff == OP_TEST_DIRECT || op_ff == OP_TEST_OFFSET8) begin
						if (cyc_ff == len_ff - 4'h1)
							mem_ff.addr <= regs_ff.pc;
					end
				end
				ST_PUSH: begin
					cyc_ff     <= cyc_ff + 4'h1;
					push_ff    <= push_ff + 3'h1;
					regs_ff.sp <= regs_ff.sp - 8'h01;
					mem_ff.addr <= {8'h00, regs_ff.sp - 8'h01};
					case (push_ff)
						3'h0: mem_ff.data <= regs_ff.pc[15:8];
						3'h1: mem_ff.data <= regs_ff.idx;
						3'h2: mem_ff.data <= regs_ff.acc;
						3'h3: mem_ff.data <= {3'h0, regs_ff.condition_code_reg};
						default: begin
							mem_ff.we                          <= 1'b0;
							mem_ff.addr                        <= TRAP_VECTOR;
							regs_ff.condition_code_reg[FLAG_I] <= 1'b1;
							state_ff           <= ST_VECTOR;
						end
					endcase
				end
				ST_VECTOR: begin
					cyc_ff <= cyc_ff + 4'h1;
					if (mem_ff.addr == TRAP_VECTOR) begin
						byte_ff     <= rdata_i;
						mem_ff.addr <= TRAP_VECTOR + 16'h0001;
					end else begin
						regs_ff.pc  <= {byte_ff, rdata_i};
						mem_ff.addr <= {byte_ff, rdata_i};
						done_ff     <= 1'b1;
						state_ff    <= ST_FETCH;
					end
				end
				ST_WAITING: begin
					if (wake_s2_ff) begin
						clk_en_ff   <= 1'b1;
						mem_ff.addr <= regs_ff.pc;
						state_ff    <= ST_FETCH;
					end
				end
				default: state_ff <= ST_FETCH;
			endcase
		end
	end

	assign mem_o        = mem_ff;
	assign regs_o       = regs_ff;
	assign cpu_clk_en_o = clk_en_ff;
	assign instr_done_o = done_ff;

	logic unused_ofs16;
	assign unused_ofs16 = ^ofs16_addr;

	chk_copy_a_x: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_COPY_ACC_TO_INDEX)
		|=> ##1 (regs_ff.idx == $past(regs_ff.acc, 2)
			&& regs_ff.condition_code_reg == $past(regs_ff.condition_code_reg, 2)))
		else $error("copy to index wrong");
	chk_copy_x_a: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_COPY_INDEX_TO_ACC)
		|=> ##1 (regs_ff.acc == $past(regs_ff.idx, 2) && state_ff == ST_FETCH))
		else $error("copy to accumulator wrong");
	chk_test_keeps: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_EXEC && op_ff[3:0] == 4'hd)
		|=> ($stable(regs_ff.condition_code_reg[FLAG_C])
			&& $stable(regs_ff.condition_code_reg[FLAG_H])
			&& $stable(regs_ff.condition_code_reg[FLAG_I])))
		else $error("test changed carry, half carry or mask");
	// done is sampled high at the fetch edge that follows the last cycle
	chk_test_reg_len: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_TEST_ACCUMULATOR)
		|=> ##1 !done_ff ##1 done_ff)
		else $error("register test length wrong");
	chk_test_ofs8_len: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_TEST_OFFSET8)
		|=> !done_ff [*4] ##1 done_ff)
		else $error("offset test length wrong");
	chk_test_dir_len: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_TEST_DIRECT)
		|=> !done_ff [*3] ##1 done_ff)
		else $error("direct test length wrong");
	chk_wait_halt: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_WAIT_IRQ)
		|=> ##1 (!clk_en_ff && !regs_ff.condition_code_reg[FLAG_I]))
		else $error("wait did not halt");
	chk_trap_vector: assert property (@(posedge mclk_i) disable iff (srst_i)
		(state_ff == ST_FETCH && rdata_i == OP_SOFTWARE_TRAP)
		|=> !done_ff [*8] ##1 !done_ff ##1 (done_ff && regs_ff.condition_code_reg[FLAG_I]
			&& regs_ff.sp == $past(regs_ff.sp, 10) - 8'h05))
		else $error("trap sequence wrong");
	cov_copy: cover property (@(posedge mclk_i) state_ff == ST_FETCH && rdata_i == OP_COPY_ACC_TO_INDEX);
	cov_test: cover property (@(posedge mclk_i) state_ff == ST_FETCH && rdata_i == OP_TEST_OFFSET8);
	cov_wait: cover property (@(posedge mclk_i) state_ff == ST_WAITING ##1 state_ff == ST_FETCH);
	cov_trap: cover property (@(posedge mclk_i) state_ff == ST_VECTOR ##1 state_ff == ST_FETCH);
endmodule

// ==== logic/xfer_test_pkg.sv ====
// constants, types and opcodes for the transfer, test, wait and trap decoder
// assumes one 10 MHz clock and a synchronous active-high reset
package xfer_test_pkg;
	localparam logic [7:0] OP_COPY_ACC_TO_INDEX = 8'h97;
	localparam logic [7:0] OP_COPY_INDEX_TO_ACC = 8'h9f;
	localparam logic [7:0] OP_TEST_DIRECT       = 8'h3d;
	localparam logic [7:0] OP_TEST_ACCUMULATOR  = 8'h4d;
	localparam logic [7:0] OP_TEST_INDEX_REG    = 8'h5d;
	localparam logic [7:0] OP_TEST_OFFSET8      = 8'h6d;
	localparam logic [7:0] OP_TEST_NO_OFFSET    = 8'h7d;
	localparam logic [7:0] OP_WAIT_IRQ          = 8'h8f;
	localparam logic [7:0] OP_SOFTWARE_TRAP     = 8'h83;

	localparam logic [3:0] CYC_COPY        = 4'h2;
	localparam logic [3:0] CYC_TEST_REG    = 4'h3;
	localparam logic [3:0] CYC_TEST_DIR    = 4'h4;
	localparam logic [3:0] CYC_TEST_NOOFS  = 4'h4;
	localparam logic [3:0] CYC_TEST_OFS8   = 4'h5;
	localparam logic [3:0] CYC_WAIT        = 4'h2;
	localparam logic [3:0] CYC_TRAP        = 4'ha;
	localparam logic [3:0] CYC_UNKNOWN     = 4'h2;

	localparam logic [7:0]  RST_SP         = 8'hff;
	localparam logic [15:0] RST_PC         = 16'h0000;
	localparam logic [15:0] TRAP_VECTOR    = 16'hfffc;

	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_I = 3;
	localparam int FLAG_H = 4;
	localparam logic [4:0] RST_FLAGS = 5'h08;

	typedef enum logic [2:0] {
		ST_FETCH   = 3'b000,
		ST_EXEC    = 3'b001,
		ST_PUSH    = 3'b011,
		ST_VECTOR  = 3'b010,
		ST_WAITING = 3'b110
	} state_t;

	typedef struct packed {
		logic [7:0]  acc;
		logic [7:0]  idx;
		logic [4:0]  condition_code_reg;
		logic [7:0]  sp;
		logic [15:0] pc;
	} cpu_regs_t;

	typedef struct packed {
		logic        we;
		logic [15:0] addr;
		logic [7:0]  data;
	} mem_req_t;

	// 16-bit indexed operand address: index plus offset fetched high then low
	function automatic logic [15:0] indexed_offset16(input logic [7:0] idx,
		input logic [7:0] hi, input logic [7:0] lo);
		indexed_offset16 = {8'h00, idx} + {hi, lo};
	endfunction
endpackage

// ==== logic/test_flags.sv ====
// flag evaluation for the test operation: operand minus zero
// assumes a combinational caller; no clock
module test_flags
	import xfer_test_pkg::*;
(
	input  wire logic [7:0] operand_i,
	input  wire logic [4:0] flags_i,
	output logic      [4:0] flags_o
);
	logic [7:0] diff;
	always_comb begin
		diff = operand_i - 8'h00;
		flags_o = flags_i;
		flags_o[FLAG_N] = diff[7];
		flags_o[FLAG_Z] = (diff == 8'h00);
	end
endmodule

// ==== bench/prog_memory.sv ====
// program and stack memory facing the decoder; reads are combinational
// assumes the decoder presents one request a cycle and writes only stack pushes
module prog_memory
	import xfer_test_pkg::*;
(
	input  wire logic     clk_i,
	input  wire mem_req_t req_i,
	output logic [7:0]    rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0]  mem [0:65535];
	logic [15:0] wr_addr_q [$];
	logic [7:0]  wr_data_q [$];

	// filler opcode the decoder treats as a two-cycle no-op
	initial begin
		for (int i = 0; i < 65536; i++) begin
			mem[i] = 8'h9d;
		end
	end

	assign rdata_o = mem[req_i.addr];

	// stack pushes are kept in order for the bench to inspect
	always @(posedge clk_i) begin
		if (req_i.we === 1'b1) begin
			mem[req_i.addr] <= req_i.data;
			wr_addr_q.push_back(req_i.addr);
			wr_data_q.push_back(req_i.data);
		end
	end

	task automatic poke(input logic [15:0] a, input logic [7:0] d);
		mem[a] = d;
	endtask
endmodule

// ==== bench/cpu_transfer_test_wait_ops_bench.sv ====
// self-checking bench for the transfer, test, wait and trap decoder
// assumes prog_memory answers reads in the same cycle
module cpu_transfer_test_wait_ops_bench
	import xfer_test_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic       mclk_i;
	logic       srst_i;
	logic       wake_i;
	logic [7:0] rdata;
	mem_req_t   mem_req;
	cpu_regs_t  regs;
	logic       clk_en;
	logic       done;
	int         failures;
	int         check_count;
	logic [7:0] prog [0:12] = '{8'h9f, 8'h3d, 8'h10, 8'h6d, 8'h20, 8'h4d, 8'h7d,
		8'h5d, 8'h97, 8'h9f, 8'h8f, 8'h97, 8'h83};

	xfer_test_core DUT (
		.mclk_i      (mclk_i),
		.srst_i      (srst_i),
		.rdata_i     (rdata),
		.wake_i      (wake_i),
		.mem_o       (mem_req),
		.regs_o      (regs),
		.cpu_clk_en_o(clk_en),
		.instr_done_o(done)
	);

	prog_memory mem_model (
		.clk_i  (mclk_i),
		.req_i  (mem_req),
		.rdata_o(rdata)
	);

	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end

	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic cmp_count(input string what, input int exp, input int got);
		check_count++;
		if (got != exp) begin
			failures++;
			$display("unexpected %s: expected %0d seen %0d", what, exp, got);
		end
	endtask

	// runs until the next completion pulse; cyc is the expected edge count, 0 skips that check
	task automatic step(input int cyc, input logic [4:0] flags);
		int n;
		n = 0;
		do begin
			@(posedge mclk_i);
			n++;
			#1;
		end while (done !== 1'b1 && n < 40);
		if (n >= 40) begin
			failures++;
			report_and_stop();
		end
		if (cyc > 0) cmp_count("cycles", cyc, n);
		cmp_val("flags", {11'h000, flags}, {11'h000, regs.condition_code_reg});
	endtask

	// index f0 plus offset 1234 fetched high then low must carry into the high byte
	task automatic run_offset16();
		cmp_val("offset16 addr", 16'h1324, indexed_offset16(8'hf0, 8'h12, 8'h34));
	endtask

	task automatic run_copies();
		step(2, 5'h0a);
		cmp_val("idx", 16'h0000, {8'h00, regs.idx});
		step(2, 5'h0a);
		cmp_val("acc", 16'h0000, {8'h00, regs.acc});
	endtask

	task automatic run_tests();
		step(4, 5'h0c);
		step(5, 5'h0a);
		step(3, 5'h0a);
		step(4, 5'h0c);
		step(3, 5'h0a);
	endtask

	task automatic run_wait();
		int n;
		logic [15:0] pc_hold;
		step(2, 5'h02);
		n = 0;
		while (clk_en !== 1'b0 && n < 5) begin
			@(posedge mclk_i);
			#1;
			n++;
		end
		cmp_val("clk_en", 16'h0000, {15'h0000, clk_en});
		pc_hold = regs.pc;
		repeat (6) @(posedge mclk_i);
		#1;
		cmp_val("pc held", pc_hold, regs.pc);
		@(posedge mclk_i);
		wake_i <= 1'b1;
		step(0, 5'h02);
		cmp_val("clk_en", 16'h0001, {15'h0000, clk_en});
		wake_i <= 1'b0;
	endtask

	task automatic run_trap();
		logic [7:0] exp_d [0:4] = '{8'h0d, 8'h00, 8'h00, 8'h00, 8'h02};
		step(10, 5'h0a);
		cmp_val("pc", 16'h1234, regs.pc);
		cmp_val("sp", 16'h00fa, {8'h00, regs.sp});
		cmp_count("pushes", 5, mem_model.wr_addr_q.size());
		for (int i = 0; i < 5 && i < mem_model.wr_addr_q.size(); i++) begin
			cmp_val("push addr", 16'h00ff - 16'(i), mem_model.wr_addr_q[i]);
			cmp_val("push data", {8'h00, exp_d[i]}, {8'h00, mem_model.wr_data_q[i]});
		end
	endtask

	initial begin
		failures = 0;
		check_count = 0;
		srst_i = 1'b1;
		wake_i = 1'b0;
		#1;
		for (int i = 0; i < 13; i++) begin
			mem_model.poke(16'(i), prog[i]);
		end
		mem_model.poke(16'h0010, 8'h80);
		mem_model.poke(16'h0020, 8'h00);
		mem_model.poke(16'hfffc, 8'h12);
		mem_model.poke(16'hfffd, 8'h34);
		repeat (3) @(posedge mclk_i);
		srst_i <= 1'b0;
		step(0, 5'h08);
		run_tests();
		run_copies();
		run_wait();
		run_trap();
		run_offset16();
		report_and_stop();
	end
endmodule
